/* usps_defines.svh */
`ifndef USPS_DEFINES_SVH
`define USPS_DEFINES_SVH

// --------------------------------------------------------------
// Clock and timing
// --------------------------------------------------------------
`define USPS_CLK_MHZ        200
`define USPS_REF_LOSS_NS    1000
`define USPS_REF_LOSS_CYC   ((`USPS_REF_LOSS_NS * `USPS_CLK_MHZ) / 1000)
`define USPS_RST_MIN_NS     1000
`define USPS_RST_MIN_CYC    (((`USPS_RST_MIN_NS * `USPS_CLK_MHZ) + 999) / 1000)
`define USPS_LOCK_EDGES     256

// --------------------------------------------------------------
// Register offsets and fields
// --------------------------------------------------------------
`define USPS_OFS_CTRL       8'h00
`define USPS_OFS_STATUS     8'h04
`define USPS_OFS_FLAGS      8'h08
`define USPS_CTRL_UART      0
`define USPS_CTRL_LVL_LO    1
`define USPS_CTRL_LVL_HI    2
`define USPS_CTRL_LPM       3
`define USPS_CTRL_RST       4'h0
`define USPS_FLAG_LOST      0
`define USPS_FLAG_POR       1
`define USPS_FLAG_SHORT     2
`define USPS_LVL_DEFAULT    2'h0

// --------------------------------------------------------------
// Reference frequencies in kHz
// --------------------------------------------------------------
`define USPS_FREQ_52M       16'hCB20
`define USPS_FREQ_38M4      16'h9600
`define USPS_FREQ_12M       16'h2EE0
`define USPS_FREQ_27M       16'h6978
`define USPS_FREQ_13M       16'h32C8
`define USPS_FREQ_19M2      16'h4B00
`define USPS_FREQ_26M       16'h6590
`define USPS_FREQ_24M       16'h5DC0
`define USPS_FREQ_60M       16'hEA60

`endif

/* usps_pkg.sv */
package usps_pkg;

    // Start-up sequence states
    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_SUPPLY = 3'b001,
        ST_PLL    = 3'b010,
        ST_STP    = 3'b011,
        ST_RUN    = 3'b100,
        ST_LOWPWR = 3'b101
    } usps_state_t;

    typedef logic [15:0] usps_khz_t;

endpackage : usps_pkg

/* usps_pll_if.sv */
interface usps_pll_if;
    logic enable;
    logic ref_edge;
    logic locked;
    logic lost;

    modport mon (input enable, output ref_edge, output locked, output lost);
    modport seq (output enable, input ref_edge, input locked, input lost);
endinterface : usps_pll_if

/* usps_pll_monitor.sv */
`include "usps_defines.svh"

module usps_pll_monitor #(
    parameter int LOCK_EDGES = `USPS_LOCK_EDGES,
    parameter int LOSS_CYC   = `USPS_REF_LOSS_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic reference_clock_input,
    usps_pll_if.mon   pll
);

    logic [2:0]  ref_sync_ff;
    logic [15:0] edge_cnt_ff;
    logic [15:0] gap_cnt_ff;
    logic        locked_ff;
    logic        lost_ff;
    wire         rise      = ref_sync_ff[1] & ~ref_sync_ff[2];
    wire         gap_full  = (gap_cnt_ff == 16'(LOSS_CYC - 1));
    wire         cnt_full  = (edge_cnt_ff == 16'(LOCK_EDGES - 1));

    // Two flops for the foreign clock, the third only feeds the edge finder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync_ff <= 3'h0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[1:0], reference_clock_input};
        end
    end

    // Lock counts only edges seen while enabled, so a late clock delays lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_ff <= 16'h0;
            gap_cnt_ff  <= 16'h0;
            locked_ff   <= 1'b0;
            lost_ff     <= 1'b0;
        end else if (!pll.enable || (gap_full && !rise)) begin
            edge_cnt_ff <= 16'h0;
            gap_cnt_ff  <= 16'h0;
            locked_ff   <= 1'b0;
            lost_ff     <= pll.enable & locked_ff;
        end else begin
            lost_ff     <= 1'b0;
            gap_cnt_ff  <= rise ? 16'h0 : gap_cnt_ff + 16'h1;
            if (rise && !locked_ff) begin
                edge_cnt_ff <= edge_cnt_ff + 16'h1;
                locked_ff   <= cnt_full;
            end
        end
    end

    assign pll.ref_edge = rise;
    assign pll.locked   = locked_ff;
    assign pll.lost     = lost_ff;

endmodule : usps_pll_monitor

/* usps_top.sv */
// Overview of operation
// - Straps 110 select 26 MHz, 111 select 24 MHz.
// - Other straps select 52, 38.4, 12, 27, 13, 19.2 MHz.
// - Clock pin high at start-up: Link supplies 60 MHz.
// - Only rising reference edges count.
// - Late reference clock delays start by the same amount.
// - Clock with reset pin low never starts the device.
// - STP exits low power; Link restarts clock with it.
// - Clock halt in run drops lock.
// - Regulators on only with reset pin high, else pulled low.
// - Core supply coming up loads register defaults.
// - 1 us reset pin low pulse restores defaults and states.
// - Run needs stable supplies, clock and reset pin high; core_supply_high_ok is only checked in ST_SUPPLY.
// - Reset pin rise may be asynchronous.
// - Supplies stable: pull data bus down, hold DIR until lock.
// - After lock, wait for STP low, then release DIR.
// - DIR stays high while STP is high.
// - In UART mode 3.3V level follows a two-bit field.
//
// Local design decisions: the APB slave port and the register addresses.
`include "usps_defines.svh"

module usps_top #(
    parameter int LOCK_EDGES = `USPS_LOCK_EDGES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reference_clock_input,
    input  wire logic        chip_reset_n,
    input  wire logic [2:0]  ref_freq_select_straps,
    input  wire logic        ulpi_clock_output_pin,
    input  wire logic        core_supply_low_ok,
    input  wire logic        core_supply_high_ok,
    input  wire logic        stp,
    output logic             dir,
    output logic             data_pulldown_en,
    output logic             regulator_en,
    output logic             regulator_pulldown_en,
    output logic      [1:0]  uart_supply_level_field,
    output logic             clock_input_mode,
    output logic             ulpi_running,
    output logic             low_power
);

    // ----------------------------------------------------------
    // Strap decoding
    // ----------------------------------------------------------
    function automatic usps_pkg::usps_khz_t ref_khz(input logic [2:0] code,
                                                   input logic       in_mode);
        usps_pkg::usps_khz_t f;
        f = `USPS_FREQ_60M;
        if (!in_mode) begin
            case (code)
                3'h0:    f = `USPS_FREQ_52M;
                3'h1:    f = `USPS_FREQ_38M4;
                3'h2:    f = `USPS_FREQ_12M;
                3'h3:    f = `USPS_FREQ_27M;
                3'h4:    f = `USPS_FREQ_13M;
                3'h5:    f = `USPS_FREQ_19M2;
                3'h6:    f = `USPS_FREQ_26M;
                3'h7:    f = `USPS_FREQ_24M;
                default: f = `USPS_FREQ_60M;
            endcase
        end
        return f;
    endfunction : ref_khz

    // ----------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    wire  [NSYNC-1:0] pins_raw = {ref_freq_select_straps, ulpi_clock_output_pin,
                                  core_supply_low_ok, core_supply_high_ok,
                                  stp, chip_reset_n};

    // Reset pin rise is asynchronous, so every pin gets two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
        end
    end

    wire       rst_pin_s = sync2_ff[0];
    wire       stp_s     = sync2_ff[1];
    wire       vhigh_s   = sync2_ff[2];
    wire       vlow_s    = sync2_ff[3];
    wire       clkpin_s  = sync2_ff[4];
    wire [2:0] straps_s  = sync2_ff[7:5];

    // ----------------------------------------------------------
    // Reset pin and power-on detection
    // ----------------------------------------------------------
    logic        rst_pin_d_ff;
    logic        vlow_d_ff;
    logic [15:0] low_cnt_ff;
    wire         pin_rise  = rst_pin_s & ~rst_pin_d_ff;
    wire         por_pulse = vlow_s & ~vlow_d_ff;
    wire         soft_clr  = ~rst_pin_s | por_pulse;
    wire         low_short = pin_rise && (low_cnt_ff < 16'(`USPS_RST_MIN_CYC));

    // Width of the last low pulse is kept to flag pulses under the minimum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_pin_d_ff <= 1'b0;
            vlow_d_ff    <= 1'b0;
            low_cnt_ff   <= 16'h0;
        end else begin
            rst_pin_d_ff <= rst_pin_s;
            vlow_d_ff    <= vlow_s;
            if (rst_pin_s) begin
                low_cnt_ff <= pin_rise ? low_cnt_ff : 16'h0;
            end else if (low_cnt_ff != 16'hFFFF) begin
                low_cnt_ff <= low_cnt_ff + 16'h1;
            end
        end
    end

    // ----------------------------------------------------------
    // PLL lock monitor
    // ----------------------------------------------------------
    usps_pll_if pll_if ();

    usps_pll_monitor #(
        .LOCK_EDGES (LOCK_EDGES),
        .LOSS_CYC   (`USPS_REF_LOSS_CYC)
    ) u_pll (
        .pclk                  (pclk),
        .presetn               (presetn),
        .reference_clock_input (reference_clock_input),
        .pll                   (pll_if)
    );

    // ----------------------------------------------------------
    // Start-up state machine
    // ----------------------------------------------------------
    usps_pkg::usps_state_t state_ff;
    usps_pkg::usps_state_t nxt_state;
    logic [3:0]  ctrl_ff;
    logic [2:0]  flags_ff;
    logic [2:0]  straps_ff;
    logic        in_mode_ff;
    logic        dir_ff;
    wire         supplies_ok = vlow_s & vhigh_s;
    wire         lpm_req     = ctrl_ff[`USPS_CTRL_LPM];

    // PLL runs only once supplies are up and outside low power
    assign pll_if.enable = (state_ff == usps_pkg::ST_PLL) ||
                           (state_ff == usps_pkg::ST_STP) ||
                           (state_ff == usps_pkg::ST_RUN);

    // Next state; reset pin low overrides everything
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            usps_pkg::ST_OFF: begin
                if (rst_pin_s) begin
                    nxt_state = usps_pkg::ST_SUPPLY;
                end
            end
            usps_pkg::ST_SUPPLY: begin
                if (supplies_ok) begin
                    nxt_state = usps_pkg::ST_PLL;
                end
            end
            usps_pkg::ST_PLL: begin
                if (pll_if.locked) begin
                    nxt_state = usps_pkg::ST_STP;
                end
            end
            usps_pkg::ST_STP: begin
                if (!pll_if.locked) begin
                    nxt_state = usps_pkg::ST_PLL;
                end else if (!stp_s) begin
                    nxt_state = usps_pkg::ST_RUN;
                end
            end
            usps_pkg::ST_RUN: begin
                if (pll_if.lost || !pll_if.locked) begin
                    nxt_state = usps_pkg::ST_PLL;
                end else if (lpm_req) begin
                    nxt_state = usps_pkg::ST_LOWPWR;
                end
            end
            usps_pkg::ST_LOWPWR: begin
                if (stp_s) begin
                    nxt_state = usps_pkg::ST_PLL;
                end
            end
            default: nxt_state = usps_pkg::ST_OFF;
        endcase
        if (!rst_pin_s || !vlow_s) begin
            nxt_state = usps_pkg::ST_OFF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= usps_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Straps and clock-mode pin are caught as the device leaves reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_ff  <= 3'h0;
            in_mode_ff <= 1'b0;
        end else if (state_ff == usps_pkg::ST_OFF && nxt_state == usps_pkg::ST_SUPPLY) begin
            straps_ff  <= straps_s;
            in_mode_ff <= clkpin_s;
        end
    end

    // ----------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    wire         acc_first = psel & penable & ~pready_ff;
    wire         commit    = psel & penable & pready_ff & pwrite;
    wire         hit_ctrl  = (paddr == `USPS_OFS_CTRL);
    wire         hit_stat  = (paddr == `USPS_OFS_STATUS);
    wire         hit_flag  = (paddr == `USPS_OFS_FLAGS);
    wire         mapped    = hit_ctrl | hit_stat | hit_flag;
    wire usps_pkg::usps_khz_t exp_khz = ref_khz(straps_ff, in_mode_ff);
    wire [31:0]  status_w  = {exp_khz, 6'h00, dir_ff, stp_s, straps_ff,
                              in_mode_ff, pll_if.locked, state_ff};
    wire [31:0]  rdata_w   = hit_ctrl ? {28'h0, ctrl_ff} :
                             hit_stat ? status_w :
                             hit_flag ? {29'h0, flags_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= acc_first;
            pslverr_ff <= acc_first & ~mapped;
            prdata_ff  <= (acc_first && !pwrite) ? rdata_w : 32'h0;
        end
    end

    // ----------------------------------------------------------
    // Control and flag registers
    // ----------------------------------------------------------
    wire [2:0] flag_set = {low_short, por_pulse, pll_if.lost};
    wire [2:0] flag_clr = (commit && hit_flag) ? pwdata[2:0] : 3'h0;

    // Defaults return on power-up and while the reset pin is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `USPS_CTRL_RST;
        end else if (soft_clr) begin
            ctrl_ff <= `USPS_CTRL_RST;
        end else if (commit && hit_ctrl) begin
            ctrl_ff <= pwdata[3:0];
        end else if (state_ff == usps_pkg::ST_LOWPWR && stp_s) begin
            ctrl_ff[`USPS_CTRL_LPM] <= 1'b0;
        end
    end

    // Sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= 3'h0;
        end else if (!rst_pin_s) begin
            flags_ff <= 3'h0;
        end else begin
            flags_ff <= (flags_ff & ~flag_clr) | flag_set;
        end
    end

    // ----------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------
    logic       pd_ff;
    logic       reg_en_ff;
    logic       reg_pd_ff;
    logic [1:0] lvl_ff;
    logic       run_ff;
    logic       lp_ff;
    wire        bus_held  = (state_ff == usps_pkg::ST_PLL) || (state_ff == usps_pkg::ST_STP);
    wire        uart_mode = ctrl_ff[`USPS_CTRL_UART];

    // DIR stays high from supplies good until lock and STP low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff    <= 1'b0;
            pd_ff     <= 1'b0;
            reg_en_ff <= 1'b0;
            reg_pd_ff <= 1'b1;
            lvl_ff    <= `USPS_LVL_DEFAULT;
            run_ff    <= 1'b0;
            lp_ff     <= 1'b0;
        end else begin
            dir_ff    <= bus_held;
            pd_ff     <= bus_held;
            reg_en_ff <= rst_pin_s;
            reg_pd_ff <= ~rst_pin_s;
            lvl_ff    <= uart_mode ? ctrl_ff[`USPS_CTRL_LVL_HI:`USPS_CTRL_LVL_LO]
                                   : `USPS_LVL_DEFAULT;
            run_ff    <= (state_ff == usps_pkg::ST_RUN);
            lp_ff     <= (state_ff == usps_pkg::ST_LOWPWR);
        end
    end

    assign prdata                  = prdata_ff;
    assign pready                  = pready_ff;
    assign pslverr                 = pslverr_ff;
    assign dir                     = dir_ff;
    assign data_pulldown_en        = pd_ff;
    assign regulator_en            = reg_en_ff;
    assign regulator_pulldown_en   = reg_pd_ff;
    assign uart_supply_level_field = lvl_ff;
    assign clock_input_mode        = in_mode_ff;
    assign ulpi_running            = run_ff;
    assign low_power               = lp_ff;

endmodule : usps_top

/* usps_checker.sv */
module usps_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        chip_reset_n,
    input wire logic        core_supply_low_ok,
    input wire logic        core_supply_high_ok,
    input wire logic        stp,
    input wire logic        dir,
    input wire logic        data_pulldown_en,
    input wire logic        regulator_en,
    input wire logic        regulator_pulldown_en,
    input wire logic [1:0]  uart_supply_level_field,
    input wire logic        clock_input_mode,
    input wire logic        ulpi_running,
    input wire logic        low_power
);
    // ----------------------------------------------------------
    // Start-up and bus properties
    // ----------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Regulator and its pull-down never overlap
    property p_reg_pair;
        regulator_en != regulator_pulldown_en;
    endproperty
    a_reg_pair: assert property (p_reg_pair) else $error("regulator pair");
    property p_dir_pull;
        dir == data_pulldown_en;
    endproperty
    a_dir_pull: assert property (p_dir_pull) else $error("pull-downs vs dir");
    // Four samples cover the pin synchroniser
    property p_stp_hold;
        (dir && stp && chip_reset_n && core_supply_low_ok && core_supply_high_ok) [*4] |=> dir;
    endproperty
    a_stp_hold: assert property (p_stp_hold) else $error("dir fell while stp high");
    property p_pin_low;
        (!chip_reset_n) [*6] |-> !ulpi_running && !dir && !regulator_en
            && uart_supply_level_field == 2'h0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("active while pin low");
    property p_run_entry;
        $rose(ulpi_running) |-> $fell(dir) && regulator_en;
    endproperty
    a_run_entry: assert property (p_run_entry) else $error("run entry");
    property p_mode_stable;
        ulpi_running |-> $stable(clock_input_mode);
    endproperty
    a_mode_stable: assert property (p_mode_stable) else $error("mode moved");
    property p_lp_excl;
        low_power |-> !ulpi_running;
    endproperty
    a_lp_excl: assert property (p_lp_excl) else $error("low power in run");
    property p_ready_slot;
        $rose(penable) && psel |=> pready;
    endproperty
    a_ready_slot: assert property (p_ready_slot) else $error("pready late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_idle_data;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("idle data");

    c_run:  cover property ($rose(ulpi_running));
    c_lp:   cover property ($rose(low_power));
    c_err:  cover property (pready && pslverr);
    c_lost: cover property ($rose(dir) && $past(ulpi_running));
endmodule : usps_checker

bind usps_top usps_checker u_checker (.*);

/* usps_link_model.sv */
module usps_link_model #(
    parameter int MIN_LOW = 200
) (
    input  wire logic       pclk,
    input  wire logic       ref_run,
    input  wire logic       rst_hold,
    input  wire logic       stp_req,
    input  wire logic       dir,
    output logic            reference_clock_input,
    output logic            chip_reset_n,
    output logic            stp,
    output logic      [7:0] link_data
);
    timeunit 1ns;
    timeprecision 100ps;
    int   low_cnt  = 0;
    logic dir_seen = 1'b0;
    logic ref_on;

    // STP also restarts the clock so wake-up latency stays short
    assign ref_on = ref_run | stp_req;
    initial reference_clock_input = 1'b0;
    always begin
        #24;
        reference_clock_input = ref_on ? ~reference_clock_input : 1'b0;
    end

    // Pin is always driven; a request can only lengthen the low pulse
    always @(posedge pclk) begin
        if (rst_hold) begin
            low_cnt <= 0;
        end else if (low_cnt < MIN_LOW) begin
            low_cnt <= low_cnt + 1;
        end
    end
    assign chip_reset_n = !rst_hold && (low_cnt >= MIN_LOW);
    assign stp          = stp_req;

    // Idle value for one cycle after dir falls, then a moving pattern
    initial link_data = 8'h00;
    always @(posedge pclk) begin
        dir_seen <= dir;
        if (dir_seen && !dir) begin
            link_data <= 8'h00;
        end else begin
            link_data <= link_data + 8'h01;
        end
    end
endmodule : usps_link_model

/* usps_top_bench.sv */
`include "usps_defines.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %0t value differs", $time); end end
module usps_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ref_clk, chip_reset_n, stp, dir, data_pulldown_en, regulator_en;
    logic        regulator_pulldown_en, clock_input_mode, ulpi_running, low_power;
    logic [1:0]  uart_supply_level_field;
    logic [2:0]  straps;
    logic        clk_pin, sup_lo, sup_hi, ref_run, rst_hold, stp_req;
    logic [3:0]  mon;
    logic [15:0] freq_tab [0:8] = '{`USPS_FREQ_52M, `USPS_FREQ_38M4, `USPS_FREQ_12M,
        `USPS_FREQ_27M, `USPS_FREQ_13M, `USPS_FREQ_19M2, `USPS_FREQ_26M, `USPS_FREQ_24M,
        `USPS_FREQ_60M};
    int          mismatches, total_checks;

    assign mon = {regulator_en, low_power, dir, ulpi_running};
    always #2.5 pclk = ~pclk;

    usps_top #(.LOCK_EDGES(8)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reference_clock_input(ref_clk),
        .chip_reset_n(chip_reset_n), .ref_freq_select_straps(straps),
        .ulpi_clock_output_pin(clk_pin), .core_supply_low_ok(sup_lo),
        .core_supply_high_ok(sup_hi), .stp(stp), .dir(dir),
        .data_pulldown_en(data_pulldown_en), .regulator_en(regulator_en),
        .regulator_pulldown_en(regulator_pulldown_en),
        .uart_supply_level_field(uart_supply_level_field),
        .clock_input_mode(clock_input_mode), .ulpi_running(ulpi_running),
        .low_power(low_power));
    usps_link_model link (.pclk(pclk), .ref_run(ref_run), .rst_hold(rst_hold),
        .stp_req(stp_req), .dir(dir), .reference_clock_input(ref_clk),
        .chip_reset_n(chip_reset_n), .stp(stp), .link_data());

    // ----------------------------------------------------------
    // Bus and wait helpers
    // ----------------------------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    // Request held until the edge that sees pready; data taken there
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) begin mismatches++; give_verdict(); end
    endtask : apb

    task waitf(input int k, input logic v);
        int n;
        n = 0;
        while (mon[k] !== v && n < 3000) begin @(posedge pclk); n++; end
        if (n >= 3000) begin mismatches++; give_verdict(); end
    endtask : waitf

    // Model stretches the pulse to the minimum
    task pin_reset;
        @(posedge pclk); rst_hold <= 1'b1;
        @(posedge pclk); rst_hold <= 1'b0;
        waitf(0, 1'b0);
    endtask : pin_reset

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; straps = 3'h0; clk_pin = 0; sup_lo = 0; sup_hi = 0;
        ref_run = 1; rst_hold = 1; stp_req = 0; mismatches = 0; total_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1; sup_lo <= 1'b1; sup_hi <= 1'b1;
        // Clock with pin low leaves the device idle
        repeat (40) @(posedge pclk);
        apb(1'b0, `USPS_OFS_STATUS, 32'h0);
        `CHK(rd[2:0], usps_pkg::ST_OFF)
        `CHK(regulator_pulldown_en, 1'b1)
        // Every strap code, then clock input mode
        for (int i = 0; i < 9; i++) begin
            straps <= i[2:0]; clk_pin <= (i == 8);
            pin_reset();
            waitf(0, 1'b1);
            apb(1'b0, `USPS_OFS_STATUS, 32'h0);
            `CHK(rd[31:16], freq_tab[i])
            `CHK({rd[4], clock_input_mode}, {2{i == 8}})
            `CHK({dir, regulator_en}, 2'h1)
        end
        // STP held high keeps dir up past lock
        stp_req <= 1'b1; clk_pin <= 1'b0;
        pin_reset();
        rd = 32'h0;
        for (int n = 0; n < 300 && rd[2:0] !== usps_pkg::ST_STP; n++) begin
            apb(1'b0, `USPS_OFS_STATUS, 32'h0);
        end
        repeat (20) @(posedge pclk);
        `CHK({dir, data_pulldown_en}, 2'h3)
        stp_req <= 1'b0;
        waitf(0, 1'b1);
        `CHK(dir, 1'b0)
        // Clock halted in run: lock lost and flagged, flag cleared by one
        ref_run <= 1'b0;
        waitf(1, 1'b1);
        `CHK(ulpi_running, 1'b0)
        apb(1'b0, `USPS_OFS_FLAGS, 32'h0);
        `CHK(rd[`USPS_FLAG_LOST], 1'b1)
        apb(1'b1, `USPS_OFS_FLAGS, 32'h1);
        apb(1'b0, `USPS_OFS_FLAGS, 32'h0);
        `CHK(rd[`USPS_FLAG_LOST], 1'b0)
        ref_run <= 1'b1;
        waitf(0, 1'b1);
        // Low power, clock stopped after the last write, woken by STP
        apb(1'b1, `USPS_OFS_CTRL, 32'h8);
        waitf(2, 1'b1);
        ref_run <= 1'b0;
        repeat (300) @(posedge pclk);
        `CHK(low_power, 1'b1)
        stp_req <= 1'b1; ref_run <= 1'b1;
        waitf(1, 1'b1);
        `CHK(low_power, 1'b0)
        stp_req <= 1'b0;
        waitf(0, 1'b1);
        apb(1'b0, `USPS_OFS_CTRL, 32'h0);
        `CHK(rd[`USPS_CTRL_LPM], 1'b0)
        // UART level follows the field only in UART mode
        apb(1'b1, `USPS_OFS_CTRL, 32'h5);
        repeat (2) @(posedge pclk);
        `CHK(uart_supply_level_field, 2'h2)
        apb(1'b1, `USPS_OFS_CTRL, 32'h4);
        repeat (2) @(posedge pclk);
        `CHK(uart_supply_level_field, 2'h0)
        // Pin pulse restores defaults; regulators off meanwhile
        apb(1'b1, `USPS_OFS_CTRL, 32'h5);
        pin_reset();
        repeat (10) @(posedge pclk);
        `CHK({regulator_en, regulator_pulldown_en}, 2'h1)
        waitf(0, 1'b1);
        apb(1'b0, `USPS_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        // Core supply coming up again loads defaults
        apb(1'b1, `USPS_OFS_CTRL, 32'h5);
        sup_lo <= 1'b0;
        repeat (10) @(posedge pclk);
        sup_lo <= 1'b1;
        waitf(0, 1'b1);
        apb(1'b0, `USPS_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, `USPS_OFS_FLAGS, 32'h0);
        `CHK(rd[`USPS_FLAG_POR], 1'b1)
        // Unmapped read errors; status write is dropped quietly
        apb(1'b0, 8'h0C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, `USPS_OFS_STATUS, 32'hFFFFFFFF);
        `CHK(err, 1'b0)
        give_verdict();
    end
endmodule : usps_top_bench
